// ===== hw/cram_pkg.sv
// package of constants and types for the register address mapper pair
// assumes a single 200 MHz core clock shared by both ends
package cram_pkg;
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam logic [7:0]  FILE_BASE      = 8'h0A;
  localparam logic [7:0]  FILE_STD_LAST  = 8'h36;
  localparam logic [7:0]  FILE_BULK      = 8'h3C;
  localparam logic [6:0]  FILE_SCALE     = 7'h64;
  localparam logic [12:0] REG_FIRST      = 13'h0001;
  localparam logic [12:0] REG_LAST       = 13'h1141;
  localparam logic [12:0] OFFSET_MAX     = 13'h1141;
  localparam logic [5:0]  BULK_ENTRIES   = 6'h20;
  localparam logic [4:0]  BULK_LAST      = 5'h1F;
  localparam int unsigned BULK_DEPTH     = 32;

  typedef enum logic [1:0] {
    CRAM_ST_OK      = 2'b00,
    CRAM_ST_BADADDR = 2'b01,
    CRAM_ST_TIMEOUT = 2'b10
  } cram_status_t;
endpackage

// ===== hw/cram_link_if.sv
// link between the client end and the device end
// both ends share CORE_CLK and RST_N
`timescale 1ns/1ps
interface cram_link_if;
  import cram_pkg::*;
  logic               req_valid;
  logic               req_write;
  logic [7:0]         req_file;
  logic [12:0]        req_offset;
  logic [5:0]         req_count;
  logic               wdata_valid;
  logic [15:0]        wdata;
  logic               rdata_valid;
  logic [15:0]        rdata;
  logic               done;
  cram_status_t       status;
  logic               busy;

  modport client (
    output req_valid, req_write, req_file, req_offset, req_count,
    output wdata_valid, wdata,
    input  rdata_valid, rdata, done, status, busy
  );
  modport device (
    input  req_valid, req_write, req_file, req_offset, req_count,
    input  wdata_valid, wdata,
    output rdata_valid, rdata, done, status, busy
  );
endinterface

// ===== hw/cram_device.sv
// device end: resolves file/offset references onto register numbers
// assumes the register store answers reads in the same cycle (comb)
`timescale 1ns/1ps
// Operation
// - register is (file minus 10) times 100 plus offset
// - files 10..54, target register 1..4417
// - offset may reach 4417
// - equal computed registers are one register
// - typed read and typed write services
// - bulk read follows produced array order
// - bulk write follows consumed array order
// - bulk offset limited to 0..31
// - bulk from k covers at most 32-k
// - link or socket fault raises timeout event
// - transfer count consecutive items from start
// - client writes only changed values; cram_client writes every word it is given, changed or not
// - client avoids writing cyclic I/O registers
// - client keeps one read outstanding
module cram_device
  import cram_pkg::*;
(
  input  wire logic           CORE_CLK,
  input  wire logic           RST_N,
  cram_link_if.device         LINK,
  input  wire logic           LINK_FAULT,
  input  wire logic           CFG_WE,
  input  wire logic           CFG_SEL_CONS,
  input  wire logic [4:0]     CFG_IDX,
  input  wire logic [12:0]    CFG_REG,
  output logic                REG_RD,
  output logic                REG_WR,
  output logic [12:0]         REG_ADDR,
  output logic [15:0]         REG_WDATA,
  input  wire logic [15:0]    REG_RDATA,
  output logic                TIMEOUT_EVT
);
  import cram_pkg::*;

  typedef enum logic [1:0] {
    CRAM_IDLE  = 2'b00,
    CRAM_READ  = 2'b01,
    CRAM_WRITE = 2'b10,
    CRAM_END   = 2'b11
  } cram_state_t;

  cram_state_t state_q;
  logic [12:0] prod_q [BULK_DEPTH];
  logic [12:0] cons_q [BULK_DEPTH];
  logic        bulk_q;
  logic [12:0] ptr_q;
  logic [5:0]  left_q;
  logic [13:0] std_reg;
  logic        std_ok;
  logic        bulk_ok;
  logic [6:0]  bulk_end;
  logic [12:0] cur_addr;
  logic [13:0] file_rel;
  logic [13:0] run_last;

  // file rebased to zero and widened before scaling
  // an 8-bit product would wrap for any file above 12
  // files below the base wrap here too; std_ok rejects them
  always_comb begin
    file_rel = 14'(LINK.req_file) - 14'(FILE_BASE);
    std_reg  = (file_rel * 14'(FILE_SCALE))
             + {1'b0, LINK.req_offset};
    run_last = std_reg + {8'h00, LINK.req_count} - 14'h0001;
  end

  // whole run checked up front: no partial transfer
  // bulk span counted on the low five offset bits only,
  // so the offset bound must hold as well

  always_comb begin
    bulk_end = {2'b00, LINK.req_offset[4:0]} + {1'b0, LINK.req_count};
    std_ok   = (LINK.req_file >= FILE_BASE)
            && (LINK.req_file <= FILE_STD_LAST)
            && (LINK.req_offset <= OFFSET_MAX)
            && (LINK.req_count != 6'h00)
            && (std_reg >= {1'b0, REG_FIRST})
            && (run_last <= {1'b0, REG_LAST});
    bulk_ok  = (LINK.req_file == FILE_BULK)
            && (LINK.req_offset <= {8'h00, BULK_LAST})
            && (LINK.req_count != 6'h00)
            && (bulk_end <= {1'b0, BULK_ENTRIES});
  end

  // bulk pointer indexes the arrays, standard pointer is the register
  // read side walks produced entries, write side consumed ones
  always_comb begin
    if (!bulk_q) begin
      cur_addr = ptr_q;
    end else if (state_q == CRAM_READ) begin
      cur_addr = prod_q[ptr_q[4:0]];
    end else begin
      cur_addr = cons_q[ptr_q[4:0]];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < BULK_DEPTH; i++) begin
        prod_q[i] <= 13'h0000;
        cons_q[i] <= 13'h0000;
      end
    end else if (CFG_WE) begin
      if (CFG_SEL_CONS) begin
        cons_q[CFG_IDX] <= CFG_REG;
      end else begin
        prod_q[CFG_IDX] <= CFG_REG;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q       <= CRAM_IDLE;
      bulk_q        <= 1'b0;
      ptr_q         <= 13'h0000;
      left_q        <= 6'h00;
      LINK.status   <= CRAM_ST_OK;
      LINK.done     <= 1'b0;
      LINK.busy     <= 1'b0;
    end else begin
      LINK.done <= 1'b0;
      case (state_q)
        CRAM_IDLE: begin
          if (LINK.req_valid) begin
            LINK.busy <= 1'b1;
            bulk_q    <= (LINK.req_file == FILE_BULK);
            ptr_q     <= (LINK.req_file == FILE_BULK)
                       ? {8'h00, LINK.req_offset[4:0]}
                       : std_reg[12:0];
            left_q    <= LINK.req_count;
            // fault wins over the address check: no access at all
            if (LINK_FAULT) begin
              LINK.status <= CRAM_ST_TIMEOUT;
              state_q     <= CRAM_END;
            end else if (!(std_ok || bulk_ok)) begin
              LINK.status <= CRAM_ST_BADADDR;
              state_q     <= CRAM_END;
            end else begin
              LINK.status <= CRAM_ST_OK;
              state_q     <= LINK.req_write ? CRAM_WRITE
                                            : CRAM_READ;
            end
          end
        end
        CRAM_READ: begin
          ptr_q  <= ptr_q + 13'h0001;
          left_q <= left_q - 6'h01;
          if (left_q == 6'h01) begin
            state_q <= CRAM_END;
          end
        end
        // write pace set by the client; extra words after count ignored
        CRAM_WRITE: begin
          if (LINK.wdata_valid) begin
            ptr_q  <= ptr_q + 13'h0001;
            left_q <= left_q - 6'h01;
            if (left_q == 6'h01) begin
              state_q <= CRAM_END;
            end
          end
        end
        CRAM_END: begin
          LINK.done <= 1'b1;
          LINK.busy <= 1'b0;
          state_q   <= CRAM_IDLE;
        end
        default: begin
          state_q <= CRAM_IDLE;
        end
      endcase
    end
  end

  // register port and returned data, registered
  // store answers combinationally, so data is taken one cycle
  // after the strobe and lines up with rdata_valid
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RD           <= 1'b0;
      REG_WR           <= 1'b0;
      REG_ADDR         <= 13'h0000;
      REG_WDATA        <= 16'h0000;
      LINK.rdata_valid <= 1'b0;
      LINK.rdata       <= 16'h0000;
    end else begin
      REG_RD           <= (state_q == CRAM_READ);
      REG_WR           <= (state_q == CRAM_WRITE) && LINK.wdata_valid;
      REG_ADDR         <= cur_addr;
      REG_WDATA        <= LINK.wdata;
      LINK.rdata_valid <= REG_RD;
      LINK.rdata       <= REG_RDATA;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TIMEOUT_EVT <= 1'b0;
    end else begin
      // level copy: stands for as long as the fault does
      TIMEOUT_EVT <= LINK_FAULT;
    end
  end
endmodule

// ===== hw/cram_client.sv
// client end: issues typed read and typed write requests on the link
// assumes the user side holds START until ACK
`timescale 1ns/1ps
module cram_client
  import cram_pkg::*;
(
  input  wire logic           CORE_CLK,
  input  wire logic           RST_N,
  cram_link_if.client         LINK,
  input  wire logic           START,
  input  wire logic           WRITE,
  input  wire logic [7:0]     FILE_NUM,
  input  wire logic [12:0]    OFFSET,
  input  wire logic [5:0]     COUNT,
  input  wire logic [15:0]    WDATA,
  output logic                WDATA_TAKE,
  output logic                ACK,
  output logic                RDATA_VALID,
  output logic [15:0]         RDATA,
  output logic                DONE,
  output logic [1:0]          STATUS
);
  import cram_pkg::*;

  logic       out_q;
  logic       wr_q;
  logic [5:0] wleft_q;

  // only one request outstanding; next one after done
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_q           <= 1'b0;
      wr_q            <= 1'b0;
      wleft_q         <= 6'h00;
      ACK             <= 1'b0;
      LINK.req_valid  <= 1'b0;
      LINK.req_write  <= 1'b0;
      LINK.req_file   <= 8'h00;
      LINK.req_offset <= 13'h0000;
      LINK.req_count  <= 6'h00;
    end else begin
      ACK            <= 1'b0;
      LINK.req_valid <= 1'b0;
      if (!out_q && START && !ACK && !LINK.busy) begin
        out_q           <= 1'b1;
        ACK             <= 1'b1;
        wr_q            <= WRITE;
        wleft_q         <= WRITE ? COUNT : 6'h00;
        LINK.req_valid  <= 1'b1;
        LINK.req_write  <= WRITE;
        LINK.req_file   <= FILE_NUM;
        LINK.req_offset <= OFFSET;
        LINK.req_count  <= COUNT;
      end else if (LINK.done) begin
        out_q   <= 1'b0;
        wleft_q <= 6'h00;
      end else if (LINK.wdata_valid) begin
        wleft_q <= wleft_q - 6'h01;
      end
    end
  end

  // write words streamed one every other cycle once the request is out
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      LINK.wdata_valid <= 1'b0;
      LINK.wdata       <= 16'h0000;
      WDATA_TAKE       <= 1'b0;
    end else begin
      LINK.wdata_valid <= 1'b0;
      WDATA_TAKE       <= 1'b0;
      if (out_q && wr_q && !LINK.req_valid && LINK.busy && !LINK.done
          && !LINK.wdata_valid && wleft_q != 6'h00) begin
        LINK.wdata_valid <= 1'b1;
        LINK.wdata       <= WDATA;
        WDATA_TAKE       <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA_VALID <= 1'b0;
      RDATA       <= 16'h0000;
      DONE        <= 1'b0;
      STATUS      <= 2'b00;
    end else begin
      RDATA_VALID <= LINK.rdata_valid;
      RDATA       <= LINK.rdata;
      DONE        <= LINK.done;
      if (LINK.done) begin
        STATUS <= LINK.status;
      end
    end
  end
endmodule

// ===== verification/cram_link_monitor.sv
// checker on the link between the client and device ends
// instantiated by the bench beside the link interface
`timescale 1ns/1ps
module cram_link_monitor
  import cram_pkg::*;
(
  input wire logic         CORE_CLK,
  input wire logic         RST_N,
  input wire logic         req_valid,
  input wire logic [7:0]   req_file,
  input wire logic [12:0]  req_offset,
  input wire logic [5:0]   req_count,
  input wire logic         rdata_valid,
  input wire logic         done,
  input wire cram_status_t status,
  input wire logic         busy
);
  logic tk;
  logic bd;

  function automatic bit bad(logic [7:0] f, logic [12:0] o, logic [5:0] c);
    int r;
    r = (int'(f) - 10) * 100 + int'(o);
    if (c == 6'h00) return 1'b1;
    if (f == FILE_BULK) return int'(o) + int'(c) > 32;
    return f < FILE_BASE || f > FILE_STD_LAST || r < 1 || r + c > 4418;
  endfunction

  // request taken by an idle device
  assign tk = req_valid && !busy;
  assign bd = bad(req_file, req_offset, req_count);

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  property p_busy; tk |=> busy; endproperty
  a_busy: assert property (p_busy) else $error("busy missing");
  property p_fall; $fell(busy) |-> done; endproperty
  a_fall: assert property (p_fall) else $error("busy fell early");
  property p_std; tk && req_file != FILE_BULK && bd
    |-> ##2 done && status == CRAM_ST_BADADDR; endproperty
  a_std: assert property (p_std) else $error("bad std ok");
  property p_bulk; tk && req_file == FILE_BULK && req_offset > 13'h001F
    |-> ##2 done && status == CRAM_ST_BADADDR; endproperty
  a_bulk: assert property (p_bulk) else $error("bulk offset");
  property p_span; tk && req_file == FILE_BULK && bd
    |-> ##2 done && status == CRAM_ST_BADADDR; endproperty
  a_span: assert property (p_span) else $error("bulk span");
  property p_quiet; tk && bd |=> !rdata_valid [*3]; endproperty
  a_quiet: assert property (p_quiet) else $error("partial data");
  property p_rdv; rdata_valid |-> busy || done; endproperty
  a_rdv: assert property (p_rdv) else $error("stray data");
  property p_pulse; done |=> !done; endproperty
  a_pulse: assert property (p_pulse) else $error("done held");
endmodule

// ===== verification/csp_register_address_mapper_test.sv
// bench joining client and device ends over the link
// register store is a combinational model here
`timescale 1ns/1ps
module csp_register_address_mapper_test;
  import cram_pkg::*;
  logic core_clk = 0, rst_n = 0, flt = 0, cwe = 0, ccons = 0;
  logic [4:0] cidx = 0;
  logic [12:0] creg = 0, off = 0;
  logic start = 0, wr = 0;
  logic [7:0] fnum = 0;
  logic [5:0] cnt = 0;
  logic [15:0] wdat = 0, rdat, rdata_m;
  logic rrd, rwr, tmo, take, ack, rdv, done;
  logic [12:0] radr, prod[32], cons[32];
  logic [15:0] rwd;
  logic [1:0] stat;
  logic [28:0] wq[$];
  logic [15:0] rq[$];
  int fails = 0, n_tests = 0, nrd, tno = 0;

  cram_link_if link();
  cram_device cram_device_inst (.CORE_CLK(core_clk), .RST_N(rst_n),
    .LINK(link), .LINK_FAULT(flt), .CFG_WE(cwe), .CFG_SEL_CONS(ccons),
    .CFG_IDX(cidx), .CFG_REG(creg), .REG_RD(rrd), .REG_WR(rwr),
    .REG_ADDR(radr), .REG_WDATA(rwd), .REG_RDATA(rdata_m),
    .TIMEOUT_EVT(tmo));
  cram_client cram_client_inst (.CORE_CLK(core_clk), .RST_N(rst_n),
    .LINK(link), .START(start), .WRITE(wr), .FILE_NUM(fnum), .OFFSET(off),
    .COUNT(cnt), .WDATA(wdat), .WDATA_TAKE(take), .ACK(ack),
    .RDATA_VALID(rdv), .RDATA(rdat), .DONE(done), .STATUS(stat));
  cram_link_monitor cram_link_monitor_inst (.CORE_CLK(core_clk),
    .RST_N(rst_n), .req_valid(link.req_valid), .req_file(link.req_file),
    .req_offset(link.req_offset), .req_count(link.req_count),
    .rdata_valid(link.rdata_valid), .done(link.done),
    .status(link.status), .busy(link.busy));

  always #2.5 core_clk = ~core_clk;

  function automatic logic [15:0] rval(logic [12:0] a);
    return {a, 3'h5} ^ 16'h3C5A;
  endfunction
  assign rdata_m = rval(radr);

  always @(posedge core_clk) begin
    if (rwr) wq.push_back({radr, rwd});
    if (rdv) rq.push_back(rdat);
    if (rrd) nrd++;
  end

  function automatic bit bad(logic [7:0] f, logic [12:0] o, logic [5:0] c);
    int r;
    r = (int'(f) - 10) * 100 + int'(o);
    if (c == 6'h00) return 1'b1;
    if (f == FILE_BULK) return int'(o) + int'(c) > 32;
    return f < FILE_BASE || f > FILE_STD_LAST || r < 1 || r + c > 4418;
  endfunction

  function automatic logic [12:0] ea(bit w, logic [7:0] f, logic [12:0] o,
                                     int i);
    if (f == FILE_BULK) return w ? cons[o + i] : prod[o + i];
    return 13'((int'(f) - 10) * 100 + int'(o) + i);
  endfunction

  task automatic chk(logic [15:0] got, logic [15:0] exp, string m);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one request, then wait for done and compare everything it moved
  task automatic run(bit w, logic [7:0] f, logic [12:0] o, logic [5:0] c);
    logic [15:0] wd[32];
    int i, k, n;
    bit b;
    b = bad(f, o, c);
    for (i = 0; i < 32; i++) wd[i] = 16'($urandom);
    wq.delete();
    rq.delete();
    nrd = 0;
    k = 0;
    @(negedge core_clk);
    {start, wr, fnum, off, cnt, wdat} = {1'b1, w, f, o, c, wd[0]};
    for (i = 0; i < 300 && done !== 1'b1; i++) begin
      @(negedge core_clk);
      if (ack) start = 0;
      if (take && k < 31) begin
        k++;
        wdat = wd[k];
      end
    end
    if (i >= 300) begin
      chk(16'h0, 16'h1, "no done");
      final_report;
    end
    chk(16'(stat), flt ? 16'h2 : (b ? 16'h1 : 16'h0), "status");
    @(posedge core_clk);
    #1;
    n = (b || flt) ? 0 : int'(c);
    chk(16'(w ? wq.size() : nrd), 16'(n), "access count");
    chk(16'(rq.size()), w ? 16'h0 : 16'(n), "word count");
    for (i = 0; i < n; i++) begin
      if (w) begin
        chk(16'(wq[i][28:16]), 16'(ea(1, f, o, i)), "waddr");
        chk(wq[i][15:0], wd[i], "wdata");
      end else begin
        chk(rq[i], rval(ea(0, f, o, i)), "rdata");
      end
    end
    tno++;
    $display("test %0d end", tno);
  endtask

  initial begin
    logic [7:0] f;
    logic [12:0] o;
    void'($urandom(73335));
    repeat (3) @(posedge core_clk);
    @(negedge core_clk) rst_n = 1;
    for (int i = 0; i < 64; i++) begin
      @(negedge core_clk);
      {cwe, ccons, cidx} = {1'b1, i[5], i[4:0]};
      creg = 13'($urandom_range(1, 4417));
      if (i[5]) cons[i[4:0]] = creg;
      else prod[i[4:0]] = creg;
    end
    @(negedge core_clk) cwe = 0;
    run(0, 8'h0A, 13'h0002, 6'h02);
    run(0, 8'h0C, 13'h003E, 6'h01);
    run(1, 8'h0B, 13'h00A2, 6'h01);
    run(1, 8'h1B, 13'h0062, 6'h03);
    run(0, 8'h14, 13'h031E, 6'h01);
    run(0, 8'h36, 13'h0011, 6'h01);
    run(0, 8'h0A, 13'h1141, 6'h01);
    run(0, 8'h36, 13'h0011, 6'h02);
    run(0, 8'h0A, 13'h0000, 6'h01);
    run(1, 8'h09, 13'h0005, 6'h01);
    run(0, 8'h37, 13'h0005, 6'h01);
    run(0, 8'h0A, 13'h0002, 6'h00);
    run(0, 8'h3C, 13'h000F, 6'h10);
    run(1, 8'h3C, 13'h0000, 6'h20);
    run(0, 8'h3C, 13'h001F, 6'h01);
    run(0, 8'h3C, 13'h001F, 6'h02);
    run(1, 8'h3C, 13'h0020, 6'h01);
    // registers written only by messages, no cyclic path here
    for (int i = 0; i < 20; i++) begin
      f = 8'(10 + $urandom % 45);
      o = 13'($urandom % 100);
      if ($urandom % 4 == 0) {f, o} = {FILE_BULK, 13'($urandom % 32)};
      run(1'($urandom), f, o, 6'(1 + $urandom % 32));
    end
    @(negedge core_clk) flt = 1;
    repeat (2) @(negedge core_clk);
    chk(16'(tmo), 16'h1, "event");
    run(0, 8'h0A, 13'h0005, 6'h04);
    flt = 0;
    repeat (2) @(negedge core_clk);
    chk(16'(tmo), 16'h0, "event off");
    final_report;
  end
endmodule
